// >>> verilog/tributary_type_select_destuff.sv
// tributary type select, alarm fill and vt1.5 destuff control
`timescale 1ns/1ps
`include "trib_consts.svh"
module tributary_type_select_destuff #(
  parameter logic [7:0] REVISION_CODE = 8'h5a // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic trib_type_strap,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [27:0] rx_line_clock,
  input wire logic [27:0] tx_line_clock,
  input wire logic [27:0] tx_line_data,
  input wire logic [27:0] tx_chan_enable,
  input wire logic t1_alarm_fill_clock,
  input wire logic e_alarm_fill_clock,
  output logic [27:0] trib_tx_clock,
  output logic [27:0] trib_tx_data,
  output logic [27:0] tx_chan_is_e1,
  output logic [27:0] rx_chan_is_e1,
  output logic overhead_fill_ones,
  output logic [1:0] pointer_size_bits,
  output logic [1:0] stuff_decision,
  input wire logic vt_bit,
  input wire logic vt_bit_valid,
  input wire logic vt_s1_slot,
  input wire logic vt_s2_slot,
  input wire logic [2:0] vt_c1_bits,
  input wire logic [2:0] vt_c2_bits,
  input wire logic vt_cbits_valid,
  output logic ds1_bit,
  output logic ds1_bit_valid
);

  function automatic logic majority3(input logic [2:0] c);
    return (c[0] & c[1]) | (c[0] & c[2]) | (c[1] & c[2]);
  endfunction

  // channels g, g+7, g+14 are the three slots an e1 group can use
  function automatic logic [2:0] group_of(input int c);
    return 3'(c % `NUM_GROUP);
  endfunction

  // ---- strap capture
  logic strap_meta, strap_sync, strap_taken, strap_ds1;
  logic [1:0] strap_wait;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
      strap_wait <= 2'b00;
    end else begin
      strap_meta <= trib_type_strap;
      strap_sync <= strap_meta;
      strap_wait <= {strap_wait[0], 1'b1};
    end
  end

  // caught once after release so a late strap change is ignored;
  // waits until the synchroniser holds the pin level, not its reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      strap_taken <= 1'b0;
      strap_ds1 <= 1'b1;
    end else if (!strap_taken && strap_wait[1]) begin
      strap_taken <= 1'b1;
      strap_ds1 <= strap_sync;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      overhead_fill_ones <= 1'b0;
      pointer_size_bits <= `PTR_SS_DS1;
    end else begin
      overhead_fill_ones <= !strap_ds1;
      pointer_size_bits <= strap_ds1 ? `PTR_SS_DS1 : `PTR_SS_E1;
    end
  end

  // ---- register port
  logic [7:0] tx_ctrl, rx_ctrl;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_ctrl <= `CTRL_RESET;
      rx_ctrl <= `CTRL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `REG_TX_TYPE) tx_ctrl <= reg_wdata;
      if (reg_addr == `REG_RX_TYPE) rx_ctrl <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `REG_REVISION: reg_rdata <= REVISION_CODE;
        `REG_TX_TYPE: reg_rdata <= tx_ctrl;
        `REG_RX_TYPE: reg_rdata <= rx_ctrl;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---- group and channel types
  trib_pkg::group_mask_type tx_group_ds1, rx_group_ds1;
  always_comb begin
    tx_group_ds1 = {`NUM_GROUP{strap_ds1}};
    rx_group_ds1 = {`NUM_GROUP{strap_ds1}};
    if (tx_ctrl[`OVR_BIT]) begin
      tx_group_ds1 = tx_ctrl[`GRP_MSB:`GRP_LSB];
    end
    if (rx_ctrl[`OVR_BIT]) begin
      rx_group_ds1 = rx_ctrl[`GRP_MSB:`GRP_LSB];
    end
  end

  trib_pkg::chan_mask_type chan_e1_type, chan_usable;
  trib_pkg::chan_mask_type next_tx_e1, next_rx_e1;
  always_comb begin
    for (int c = 0; c < `NUM_CHAN; c++) begin
      chan_e1_type[c] = tx_group_ds1[group_of(c)] == trib_pkg::TRIB_E1;
      // an e1 group has no fourth slot: those channels send only the e1 fill clock and all-ones data
      chan_usable[c] = !chan_e1_type[c] || (c < `E1_MAX_CHAN);
      next_tx_e1[c] = chan_e1_type[c] && (c < `E1_MAX_CHAN);
      next_rx_e1[c] = (rx_group_ds1[group_of(c)] == trib_pkg::TRIB_E1)
                      && (c < `E1_MAX_CHAN);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_chan_is_e1 <= '0;
      rx_chan_is_e1 <= '0;
    end else begin
      tx_chan_is_e1 <= next_tx_e1;
      rx_chan_is_e1 <= next_rx_e1;
    end
  end

  // ---- pin synchronisers
  trib_pkg::chan_mask_type rxc_meta, rxc_sync, rxc_prev;
  trib_pkg::chan_mask_type txc_meta, txc_sync, txd_meta, txd_sync;
  logic [1:0] fill_meta, fill_sync;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rxc_meta <= '0;
      rxc_sync <= '0;
      rxc_prev <= '0;
      txc_meta <= '0;
      txc_sync <= '0;
      txd_meta <= '0;
      txd_sync <= '0;
      fill_meta <= 2'b00;
      fill_sync <= 2'b00;
    end else begin
      rxc_meta <= rx_line_clock;
      rxc_sync <= rxc_meta;
      rxc_prev <= rxc_sync;
      txc_meta <= tx_line_clock;
      txc_sync <= txc_meta;
      txd_meta <= tx_line_data;
      txd_sync <= txd_meta;
      fill_meta <= {e_alarm_fill_clock, t1_alarm_fill_clock};
      fill_sync <= fill_meta;
    end
  end

  // ---- loss of input clock per channel
  logic [6:0] loc_count [`NUM_CHAN];
  trib_pkg::chan_mask_type clock_lost;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < `NUM_CHAN; c++) loc_count[c] <= 7'h00;
      clock_lost <= '1;
    end else begin
      for (int c = 0; c < `NUM_CHAN; c++) begin
        if (rxc_sync[c] != rxc_prev[c]) begin
          loc_count[c] <= 7'h00;
          clock_lost[c] <= 1'b0;
        end else if (loc_count[c] == 7'(`LOC_CYCLES)) begin
          clock_lost[c] <= 1'b1;
        end else begin
          loc_count[c] <= loc_count[c] + 7'h01;
        end
      end
    end
  end

  // ---- output source select
  // the source only changes while both the old and the new clock are
  // low, so the switch never cuts a high phase short; a lost clock still can
  trib_pkg::chan_mask_type want_fill, use_fill, fill_clk, cur_src, new_src;
  always_comb begin
    for (int c = 0; c < `NUM_CHAN; c++) begin
      want_fill[c] = clock_lost[c] || !tx_chan_enable[c]
                     || !chan_usable[c];
      fill_clk[c] = chan_e1_type[c] ? fill_sync[1]
                                    : fill_sync[0];
      // a lost line clock may hang high: it is read as low so the
      // switch can still happen; a live tx clock is cut short then
      cur_src[c] = use_fill[c] ? fill_clk[c]
                               : (txc_sync[c] && !clock_lost[c]);
      new_src[c] = want_fill[c] ? fill_clk[c] : txc_sync[c];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      use_fill <= '1;
    end else begin
      for (int c = 0; c < `NUM_CHAN; c++) begin
        if (!cur_src[c] && !new_src[c] && !trib_tx_clock[c]) begin
          use_fill[c] <= want_fill[c];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trib_tx_clock <= '0;
      trib_tx_data <= '1;
    end else begin
      trib_tx_clock <= cur_src;
      trib_tx_data <= use_fill | txd_sync;
    end
  end

  // ---- destuff on the link clock
  logic s1_stuff, s2_stuff, dec_toggle;
  logic [1:0] dec_word;
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      s1_stuff <= 1'b0;
      s2_stuff <= 1'b0;
      dec_word <= 2'b00;
      dec_toggle <= 1'b0;
    end else if (vt_cbits_valid) begin
      s1_stuff <= majority3(vt_c1_bits);
      s2_stuff <= majority3(vt_c2_bits);
      dec_word <= {majority3(vt_c2_bits), majority3(vt_c1_bits)};
      dec_toggle <= !dec_toggle;
    end
  end

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      ds1_bit <= 1'b0;
      ds1_bit_valid <= 1'b0;
    end else begin
      ds1_bit <= vt_bit;
      ds1_bit_valid <= vt_bit_valid && !(vt_s1_slot && s1_stuff)
                       && !(vt_s2_slot && s2_stuff);
    end
  end

  // decision word is held a whole superframe, far longer than the
  // toggle needs to cross, so it is sampled without its own sync
  logic tog_meta, tog_sync, tog_prev;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_prev <= 1'b0;
      stuff_decision <= 2'b00;
    end else begin
      tog_meta <= dec_toggle;
      tog_sync <= tog_meta;
      tog_prev <= tog_sync;
      if (tog_sync != tog_prev) stuff_decision <= dec_word;
    end
  end

  // ---- checks
  property p_cbit_vote;
    @(posedge link_clk) disable iff (!rstn)
      vt_cbits_valid |=> (s1_stuff == ($countones($past(vt_c1_bits)) >= 2))
                         && (s2_stuff == ($countones($past(vt_c2_bits)) >= 2));
  endproperty
  a_cbit_vote: assert property (p_cbit_vote)
    else $error("c bit vote wrong");

  property p_drop_bit;
    @(posedge link_clk) disable iff (!rstn)
      vt_bit_valid && ((vt_s1_slot && s1_stuff) || (vt_s2_slot && s2_stuff))
      |=> !ds1_bit_valid;
  endproperty
  a_drop_bit: assert property (p_drop_bit)
    else $error("stuff bit not dropped");

  property p_keep_bit;
    @(posedge link_clk) disable iff (!rstn)
      vt_bit_valid && !vt_s1_slot && !vt_s2_slot
      |=> ds1_bit_valid && ds1_bit == $past(vt_bit);
  endproperty
  a_keep_bit: assert property (p_keep_bit)
    else $error("data bit lost");

  property p_strap_ds1;
    @(posedge clk_sys) disable iff (!rstn)
      strap_taken && strap_ds1 |=> !overhead_fill_ones
                                   && pointer_size_bits == 2'b00;
  endproperty
  a_strap_ds1: assert property (p_strap_ds1)
    else $error("ds1 default fill wrong");

  property p_strap_e1;
    @(posedge clk_sys) disable iff (!rstn)
      strap_taken && !strap_ds1 |=> overhead_fill_ones
                                    && pointer_size_bits == 2'b10;
  endproperty
  a_strap_e1: assert property (p_strap_e1)
    else $error("e1 default fill wrong");

  property p_override;
    @(posedge clk_sys) disable iff (!rstn)
      reg_wr && reg_addr == 8'h88 && reg_wdata[0] && !reg_wdata[1]
      ##2 1 |-> tx_chan_is_e1[0] && tx_chan_is_e1[7];
  endproperty
  a_override: assert property (p_override)
    else $error("override group type not applied");

  property p_e1_range;
    @(posedge clk_sys) disable iff (!rstn)
      tx_chan_is_e1[27:21] == 7'h00 && rx_chan_is_e1[27:21] == 7'h00;
  endproperty
  a_e1_range: assert property (p_e1_range)
    else $error("e1 above channel 21");

  property p_fill_ones;
    @(posedge clk_sys) disable iff (!rstn)
      use_fill[3] |=> trib_tx_data[3];
  endproperty
  a_fill_ones: assert property (p_fill_ones)
    else $error("fill data not all ones");

  property p_revision;
    @(posedge clk_sys) disable iff (!rstn)
      reg_rd && reg_addr == 8'h16 |=> reg_rdata == REVISION_CODE;
  endproperty
  a_revision: assert property (p_revision)
    else $error("revision read wrong");

  property p_strap_once;
    @(posedge clk_sys) disable iff (!rstn)
      strap_taken |=> strap_ds1 == $past(strap_ds1);
  endproperty
  a_strap_once: assert property (p_strap_once)
    else $error("strap value changed");

  property p_no_runt;
    @(posedge clk_sys) disable iff (!rstn)
      use_fill[0] != $past(use_fill[0]) |-> !$past(trib_tx_clock[0])
                                            && !trib_tx_clock[0];
  endproperty
  a_no_runt: assert property (p_no_runt)
    else $error("source switched while clock high");

  c_stuff: cover property (@(posedge link_clk) disable iff (!rstn)
    vt_bit_valid && vt_s1_slot && s1_stuff);
  c_fill_on: cover property (@(posedge clk_sys) disable iff (!rstn)
    $rose(use_fill[0]));
  c_override: cover property (@(posedge clk_sys) disable iff (!rstn)
    tx_ctrl[0] && rx_ctrl[0]);
  c_decision: cover property (@(posedge clk_sys) disable iff (!rstn)
    stuff_decision == 2'b11);

endmodule

// >>> verilog/trib_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef TRIB_CONSTS_SVH
`define TRIB_CONSTS_SVH
`define REG_REVISION 8'h16
`define REG_TX_TYPE 8'h88
`define REG_RX_TYPE 8'h89
`define OVR_BIT 0
`define GRP_LSB 1
`define GRP_MSB 7
`define CTRL_RESET 8'h00
`define PTR_SS_DS1 2'b00
`define PTR_SS_E1 2'b10
`define NUM_CHAN 28
`define NUM_GROUP 7
`define E1_MAX_CHAN 21
`define SYS_PERIOD_NS 25
`define LOC_TIME_NS 1600
`define LOC_CYCLES (`LOC_TIME_NS / `SYS_PERIOD_NS)
`endif

// >>> verilog/trib_pkg.sv
// types shared by the tributary type select block
package trib_pkg;
  typedef enum logic {
    TRIB_E1 = 1'b0,
    TRIB_DS1 = 1'b1
  } trib_kind_type;
  typedef logic [6:0] group_mask_type;
  typedef logic [27:0] chan_mask_type;
endpackage

// >>> bench/trib_line_model.sv
// line transceiver model: line clocks, line data and both fill clocks
`timescale 1ns/1ps
module trib_line_model (
  input wire logic [27:0] run,
  output logic [27:0] rx_line_clock,
  output logic [27:0] tx_line_clock,
  output logic [27:0] tx_line_data,
  output logic t1_alarm_fill_clock,
  output logic e_alarm_fill_clock
);
  logic ck = 1'b0;
  logic [27:0] pat = 28'h5a5a5a5;
  initial begin
    t1_alarm_fill_clock = 1'b0;
    e_alarm_fill_clock = 1'b0;
  end
  // line rate kept apart from the fill rates so the source is visible
  always #380 ck = ~ck;
  always #324 t1_alarm_fill_clock = ~t1_alarm_fill_clock;
  always #244 e_alarm_fill_clock = ~e_alarm_fill_clock;
  always @(negedge ck) pat <= ~pat;
  // a stopped clock pin floats up through its pull-up
  assign rx_line_clock = ({28{ck}} & run) | ~run;
  assign tx_line_clock = ({28{ck}} & run) | ~run;
  assign tx_line_data = pat;
endmodule

// >>> bench/tributary_type_select_destuff_tb.sv
// self-checking bench for the tributary type select block
`timescale 1ns/1ps
module tributary_type_select_destuff_tb;
  logic clk_sys = 1'b0;
  logic link_clk = 1'b0;
  logic rstn = 1'b0;
  logic trib_type_strap = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, rd_val;
  logic [27:0] run = '1;
  logic [27:0] tx_chan_enable = '1;
  logic [27:0] rx_line_clock, tx_line_clock, tx_line_data;
  logic t1_alarm_fill_clock, e_alarm_fill_clock;
  logic [27:0] trib_tx_clock, trib_tx_data, tx_chan_is_e1, rx_chan_is_e1;
  logic overhead_fill_ones, ds1_bit, ds1_bit_valid;
  logic [1:0] pointer_size_bits, stuff_decision;
  logic vt_bit = 1'b1;
  logic vt_bit_valid = 1'b0;
  logic vt_s1_slot = 1'b0;
  logic vt_s2_slot = 1'b0;
  logic vt_cbits_valid = 1'b0;
  logic [2:0] vt_c1_bits = 3'h0;
  logic [2:0] vt_c2_bits = 3'h0;
  int fail_count = 0;
  int check_count = 0;

  tributary_type_select_destuff dut_u (.clk_sys, .rstn, .link_clk,
    .trib_type_strap, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .rx_line_clock, .tx_line_clock, .tx_line_data, .tx_chan_enable,
    .t1_alarm_fill_clock, .e_alarm_fill_clock, .trib_tx_clock,
    .trib_tx_data, .tx_chan_is_e1, .rx_chan_is_e1, .overhead_fill_ones,
    .pointer_size_bits, .stuff_decision, .vt_bit, .vt_bit_valid,
    .vt_s1_slot, .vt_s2_slot, .vt_c1_bits, .vt_c2_bits, .vt_cbits_valid,
    .ds1_bit, .ds1_bit_valid);
  trib_line_model line_u (.run, .rx_line_clock, .tx_line_clock,
    .tx_line_data, .t1_alarm_fill_clock, .e_alarm_fill_clock);

  initial forever #12.5 clk_sys = ~clk_sys;
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end

  task chk(input string name, input logic [27:0] exp, input logic [27:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    rd_val = reg_rdata;
  endtask

  // e1 only where the group says so and the channel is below 21
  function logic [27:0] exp_e1(input logic [7:0] r);
    logic [27:0] e;
    for (int c = 0; c < 28; c++) e[c] = (c < 21) && !r[c % 7 + 1];
    return e;
  endfunction

  // counts output clock edges over 40 us and watches the data level
  task clk_chk(input int c, input int lo, input int hi, input logic ones);
    int n;
    logic all1;
    logic prev;
    n = 0;
    all1 = 1'b1;
    repeat (200) @(posedge clk_sys);
    prev = trib_tx_clock[c];
    repeat (1600) begin
      @(posedge clk_sys);
      if (trib_tx_clock[c] && !prev) n++;
      prev = trib_tx_clock[c];
      all1 = all1 & trib_tx_data[c];
    end
    chk("tx_data_ones", 28'(ones), 28'(all1));
    chk("tx_clock_edges", 28'h1, 28'(n >= lo && n <= hi));
  endtask

  task stuff(input logic [2:0] a, input logic [2:0] b);
    logic [1:0] e;
    e[0] = $countones(a) >= 2;
    e[1] = $countones(b) >= 2;
    @(posedge link_clk);
    vt_c1_bits <= a;
    vt_c2_bits <= b;
    vt_cbits_valid <= 1'b1;
    @(posedge link_clk);
    vt_cbits_valid <= 1'b0;
    vt_bit_valid <= 1'b1;
    vt_s1_slot <= 1'b1;
    @(posedge link_clk);
    vt_s1_slot <= 1'b0;
    vt_s2_slot <= 1'b1;
    @(posedge link_clk);
    vt_s2_slot <= 1'b0;
    vt_bit <= a[0];
    chk("s1_kept", 28'(!e[0]), 28'(ds1_bit_valid));
    @(posedge link_clk);
    vt_bit_valid <= 1'b0;
    chk("s2_kept", 28'(!e[1]), 28'(ds1_bit_valid));
    @(posedge link_clk);
    chk("data_kept", 28'h1, 28'(ds1_bit_valid));
    chk("data_bit", 28'(a[0]), 28'(ds1_bit));
    @(posedge link_clk);
    chk("stuff_decision", 28'(e), 28'(stuff_decision));
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #1000000;
    fail_count++;
    wrap_up;
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("pointer_size", 28'h0, 28'(pointer_size_bits));
    chk("fill_ones", 28'h0, 28'(overhead_fill_ones));
    chk("tx_is_e1", 28'h0, tx_chan_is_e1);
    chk("rx_is_e1", 28'h0, rx_chan_is_e1);
    rd(8'h16);
    chk("revision", 28'h5a, 28'(rd_val));
    wr(8'h16, 8'hff);
    rd(8'h16);
    chk("revision_wr", 28'h5a, 28'(rd_val));
    rd(8'h40);
    chk("unmapped", 28'h0, 28'(rd_val));
    wr(8'h88, 8'hfb);
    wr(8'h89, 8'h55);
    rd(8'h88);
    chk("tx_ctrl", 28'hfb, 28'(rd_val));
    rd(8'h89);
    chk("rx_ctrl", 28'h55, 28'(rd_val));
    chk("tx_is_e1", exp_e1(8'hfb), tx_chan_is_e1);
    chk("rx_is_e1", exp_e1(8'h55), rx_chan_is_e1);
    // unprovisioned ds1 on 0, unprovisioned e1 on 1, lost clock on 2
    tx_chan_enable <= 28'hffffffc;
    run <= 28'hffffffb;
    clk_chk(0, 60, 63, 1'b1);
    clk_chk(1, 80, 83, 1'b1);
    clk_chk(2, 60, 63, 1'b1);
    clk_chk(27, 51, 54, 1'b0);
    wr(8'h88, 8'hfd);
    repeat (2) @(posedge clk_sys);
    chk("tx_is_e1_g0", exp_e1(8'hfd), tx_chan_is_e1);
    wr(8'h88, 8'h00);
    repeat (4) @(posedge clk_sys);
    chk("tx_is_e1_off", 28'h0, tx_chan_is_e1);
    for (int i = 0; i < 8; i++) begin
      stuff(i[2:0], i[2:0]);
      stuff(i[2:0], ~i[2:0]);
    end
    // second reset with the strap low
    rstn <= 1'b0;
    trib_type_strap <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("pointer_size", 28'h2, 28'(pointer_size_bits));
    chk("fill_ones", 28'h1, 28'(overhead_fill_ones));
    chk("tx_is_e1", exp_e1(8'h00), tx_chan_is_e1);
    chk("rx_is_e1", exp_e1(8'h00), rx_chan_is_e1);
    wrap_up;
  end
endmodule
